// ==== fast_detect_pkg.sv ====
// package: register map, field layout, latencies and carrier types for the fast detect block
package fast_detect_pkg;

    localparam int SAMPLE_W = 14;
    localparam int THRESH_W = 16;
    localparam int DWELL_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] FAST_DETECT_CONTROL_ADDR = 8'h45;
    localparam logic [7:0] UPPER_THRESHOLD_LOW_ADDR = 8'h47;
    localparam logic [7:0] UPPER_THRESHOLD_HIGH_ADDR = 8'h48;
    localparam logic [7:0] LOWER_THRESHOLD_LOW_ADDR = 8'h49;
    localparam logic [7:0] LOWER_THRESHOLD_HIGH_ADDR = 8'h4A;
    localparam logic [7:0] DWELL_TIME_LOW_ADDR = 8'h4B;
    localparam logic [7:0] DWELL_TIME_HIGH_ADDR = 8'h4C;

    // field positions
    localparam int FD_ENABLE_BIT = 0;

    // values after reset
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] UPPER_RESET = 16'h0000;
    localparam logic [15:0] LOWER_RESET = 16'h0000;
    localparam logic [15:0] DWELL_RESET = 16'h0001;

    // latencies in sample clock cycles
    localparam int FD_LATENCY = 7;
    localparam int OVR_LATENCY = 36;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic [SAMPLE_W-1:0] data;
        logic over;
    } sample_type;

    typedef struct packed {
        logic enable;
        logic [THRESH_W-1:0] upper;
        logic [THRESH_W-1:0] lower;
        logic [DWELL_W-1:0] dwell;
    } fd_cfg_type;

endpackage : fast_detect_pkg

// ==== fd_delay_line.sv ====
// delay line: fixed-length shift pipeline for flag bits
`timescale 1ns/10ps
module fd_delay_line #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // data
    input wire logic [WIDTH-1:0] din_i,
    output logic [WIDTH-1:0] dout_o
);
    logic [WIDTH-1:0] stage_q [DEPTH];

    // refuse a line that cannot hold a single stage
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
        $error("fd_delay_line: depth and width must be at least 1");
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_q[i] <= '0;
            end
        end else begin
            stage_q[0] <= din_i;
            for (int i = 1; i < DEPTH; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign dout_o = stage_q[DEPTH-1];
endmodule : fd_delay_line

// ==== fd_regfile.sv ====
// register file: byte-wide configuration registers for fast detect
`timescale 1ns/10ps
module fd_regfile (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // register port
    input fast_detect_pkg::reg_req_type req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // configuration out
    output fast_detect_pkg::fd_cfg_type cfg_o
);
    import fast_detect_pkg::*;

    logic [7:0] control_q;
    logic [15:0] upper_q;
    logic [15:0] lower_q;
    logic [15:0] dwell_q;
    logic [7:0] rdata_d;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_q <= CONTROL_RESET;
            upper_q <= UPPER_RESET;
            lower_q <= LOWER_RESET;
            dwell_q <= DWELL_RESET;
        end else if (req_i.wr_en) begin
            case (req_i.addr)
                FAST_DETECT_CONTROL_ADDR: control_q <= req_i.wdata;
                UPPER_THRESHOLD_LOW_ADDR: upper_q[7:0] <= req_i.wdata; // see RULE7
                UPPER_THRESHOLD_HIGH_ADDR: upper_q[15:8] <= req_i.wdata; // see RULE7
                LOWER_THRESHOLD_LOW_ADDR: lower_q[7:0] <= req_i.wdata; // see RULE11
                LOWER_THRESHOLD_HIGH_ADDR: lower_q[15:8] <= req_i.wdata; // see RULE11
                DWELL_TIME_LOW_ADDR: dwell_q[7:0] <= req_i.wdata; // see RULE12
                DWELL_TIME_HIGH_ADDR: dwell_q[15:8] <= req_i.wdata; // see RULE12
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (req_i.addr)
            FAST_DETECT_CONTROL_ADDR: rdata_d = control_q;
            UPPER_THRESHOLD_LOW_ADDR: rdata_d = upper_q[7:0];
            UPPER_THRESHOLD_HIGH_ADDR: rdata_d = upper_q[15:8];
            LOWER_THRESHOLD_LOW_ADDR: rdata_d = lower_q[7:0];
            LOWER_THRESHOLD_HIGH_ADDR: rdata_d = lower_q[15:8];
            DWELL_TIME_LOW_ADDR: rdata_d = dwell_q[7:0];
            DWELL_TIME_HIGH_ADDR: rdata_d = dwell_q[15:8];
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd_en;
            if (req_i.rd_en) begin
                rdata_o <= rdata_d;
            end
        end
    end

    assign cfg_o.enable = control_q[FD_ENABLE_BIT];
    assign cfg_o.upper = upper_q;
    assign cfg_o.lower = lower_q;
    // a dwell of zero is served as one cycle
    assign cfg_o.dwell = (dwell_q == 16'h0000) ? 16'h0001 : dwell_q; // see RULE12
endmodule : fd_regfile

// ==== adc_overrange_fast_detect.sv ====
// top: fast threshold detection and overrange flag on the converter output samples
// What this block does
// RULE1: detection runs only while control bit 0 set
// RULE2: flag set when magnitude exceeds upper threshold
// RULE3: flag low while signal below threshold
// RULE4: compare magnitude only, sign ignored
// RULE5: compare converter output sample, not analogue input
// RULE6: upper crossing shows on flag after seven cycles
// RULE7: thresholds programmed through four byte registers
// RULE8: overrange flag follows converter overrange
// RULE9: overrange flag appears 36 cycles after event
// RULE10: flag clears after dwell below lower threshold
// RULE11: lower threshold is 16 bits, two bytes
// RULE12: dwell programmable 1 to 65535 cycles
// RULE13: both flags registered, low after reset
`timescale 1ns/10ps
module adc_overrange_fast_detect (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // converter core output, one sample per clock
    input fast_detect_pkg::sample_type sample_i,
    // configuration register port
    input fast_detect_pkg::reg_req_type reg_req_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // flags to gain control logic
    output logic fast_detect_flag_o,
    output logic overrange_flag_o
);
    import fast_detect_pkg::*;

    typedef enum logic [1:0] {
        FD_IDLE = 2'b00,
        FD_HIGH = 2'b01,
        FD_DWELL = 2'b10
    } fd_state_type;

    fd_cfg_type cfg;
    fd_state_type state_q;
    fd_state_type state_d;
    logic [15:0] mag_q;
    logic [DWELL_W-1:0] dwell_cnt_q;
    logic above_upper;
    logic below_lower;
    logic fd_raw;
    logic fd_delayed;
    logic ovr_delayed;

    // two's complement sample to unsigned magnitude, widened to threshold width
    function automatic logic [15:0] magnitude(input logic [SAMPLE_W-1:0] s);
        logic [SAMPLE_W-1:0] m;
        m = s[SAMPLE_W-1] ? (~s + 1'b1) : s;
        // the most negative code wraps to itself; return its true magnitude 8192
        if (s[SAMPLE_W-1] && m[SAMPLE_W-1]) begin
            return 16'(1) << (SAMPLE_W - 1);
        end
        return 16'(m);
    endfunction : magnitude

    fd_regfile u_regfile (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .req_i(reg_req_i),
        .rdata_o(reg_rdata_o),
        .rvalid_o(reg_rvalid_o),
        .cfg_o(cfg)
    );

    // stage 1: magnitude of the core output sample
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mag_q <= 16'h0000;
        end else begin
            mag_q <= magnitude(sample_i.data); // see RULE4 // see RULE5
        end
    end

    assign above_upper = (mag_q > cfg.upper); // see RULE2
    assign below_lower = (mag_q < cfg.lower); // see RULE11

    // hysteresis state: set on upper crossing, clear after dwell below lower
    always_comb begin
        state_d = state_q;
        case (state_q)
            FD_IDLE: begin
                if (above_upper) begin
                    state_d = FD_HIGH; // see RULE2
                end
            end
            FD_HIGH: begin
                if (!above_upper && below_lower) begin
                    state_d = (cfg.dwell == 16'h0001) ? FD_IDLE : FD_DWELL;
                end
            end
            FD_DWELL: begin
                if (above_upper || !below_lower) begin
                    state_d = FD_HIGH; // see RULE10
                end else if (dwell_cnt_q + 16'h0001 >= cfg.dwell) begin
                    state_d = FD_IDLE; // see RULE10
                end
            end
            default: state_d = FD_IDLE;
        endcase
        if (!cfg.enable) begin
            state_d = FD_IDLE; // see RULE1
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= FD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // dwell counter: cycles spent below the lower threshold
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dwell_cnt_q <= '0;
        end else if (state_d == FD_DWELL && state_q == FD_DWELL) begin
            dwell_cnt_q <= dwell_cnt_q + 16'h0001; // see RULE12
        end else begin
            dwell_cnt_q <= 16'h0001;
        end
    end

    // raw flag is high from the state update; zero in FD_IDLE or while disabled
    assign fd_raw = (state_q != FD_IDLE) && cfg.enable; // see RULE3 // see RULE1

    // sample in -> mag_q -> state_q is two edges; the four-stage line and the output register add the rest of seven
    fd_delay_line #(
        .WIDTH(1),
        .DEPTH(FD_LATENCY - 3)
    ) u_fd_delay (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .din_i(fd_raw),
        .dout_o(fd_delayed)
    ); // see RULE6

    // overrange flag: one output register closes the 36-cycle pipeline
    fd_delay_line #(
        .WIDTH(1),
        .DEPTH(OVR_LATENCY - 1)
    ) u_ovr_delay (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .din_i(sample_i.over),
        .dout_o(ovr_delayed)
    ); // see RULE8 // see RULE9

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fast_detect_flag_o <= 1'b0;
            overrange_flag_o <= 1'b0;
        end else begin
            fast_detect_flag_o <= fd_delayed; // see RULE13 // see RULE6
            overrange_flag_o <= ovr_delayed; // see RULE13 // see RULE9
        end
    end
endmodule : adc_overrange_fast_detect

// ==== fd_checker_assertions.sv ====
// checker: flag latency, lower threshold and read answer relations at the fast detect ports
`timescale 1ns/10ps
module fd_checker (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // watched ports
    input fast_detect_pkg::sample_type sample_i,
    input fast_detect_pkg::reg_req_type reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic fast_detect_flag_o,
    input wire logic overrange_flag_o
);
    import fast_detect_pkg::*;
    logic en_q;
    logic [15:0] up_q;
    logic [15:0] lo_q;
    logic [15:0] mag;
    logic hit;
    logic low;
    assign mag = sample_i.data[13] ? 16'(~sample_i.data) + 16'h0001 : 16'(sample_i.data);
    assign hit = en_q && (mag > up_q);
    assign low = !en_q || (mag < lo_q);
    // shadow of the configuration writes
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_q <= 1'b0;
            up_q <= UPPER_RESET;
            lo_q <= LOWER_RESET;
        end else if (reg_req_i.wr_en) begin
            case (reg_req_i.addr)
                FAST_DETECT_CONTROL_ADDR: en_q <= reg_req_i.wdata[FD_ENABLE_BIT];
                UPPER_THRESHOLD_LOW_ADDR: up_q[7:0] <= reg_req_i.wdata;
                UPPER_THRESHOLD_HIGH_ADDR: up_q[15:8] <= reg_req_i.wdata;
                LOWER_THRESHOLD_LOW_ADDR: lo_q[7:0] <= reg_req_i.wdata;
                LOWER_THRESHOLD_HIGH_ADDR: lo_q[15:8] <= reg_req_i.wdata;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    AST_FD_SET: assert property (hit |-> ##7 fast_detect_flag_o)
        else $error("flag missing after crossing");
    AST_FD_RISE: assert property ($rose(fast_detect_flag_o) |-> $past(hit, 7))
        else $error("flag rose without crossing");
    AST_FD_FALL: assert property ($fell(fast_detect_flag_o) |-> $past(low, 7))
        else $error("flag fell on sample not below lower");
    AST_FD_OFF: assert property ((!en_q) [*8] |-> !fast_detect_flag_o)
        else $error("flag high while disabled");
    AST_OVR_SET: assert property (sample_i.over |-> ##36 overrange_flag_o)
        else $error("overrange flag late or missing");
    AST_OVR_CLR: assert property (!sample_i.over |-> ##36 !overrange_flag_o)
        else $error("overrange flag without event");
    AST_RD_ANS: assert property (reg_req_i.rd_en |=> reg_rvalid_o)
        else $error("read answer missing");
    AST_RD_IDLE: assert property (!reg_req_i.rd_en |=> !reg_rvalid_o)
        else $error("read answer without request");
endmodule : fd_checker
bind adc_overrange_fast_detect fd_checker u_chk (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .sample_i(sample_i),
    .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .fast_detect_flag_o(fast_detect_flag_o),
    .overrange_flag_o(overrange_flag_o)
);

// ==== gain_ctrl_model.sv ====
// gain control model: counts trips seen on the fast detect flag pin
`timescale 1ns/10ps
module gain_ctrl_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // flag pin and trip count
    input wire logic flag_i,
    output logic [7:0] trip_count_o
);
    logic seen_q;
    // one attenuator step per rising edge of the flag
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_q <= 1'b0;
            trip_count_o <= 8'h00;
        end else begin
            seen_q <= flag_i;
            if (flag_i && !seen_q) begin
                trip_count_o <= trip_count_o + 8'h01;
            end
        end
    end
endmodule : gain_ctrl_model

// ==== test_adc_overrange_fast_detect.sv ====
// testbench: register access, flag latency, dwell and overrange scenarios
`timescale 1ns/10ps
module test_adc_overrange_fast_detect;
    import fast_detect_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    sample_type samp = '0;
    reg_req_type req = '0;
    logic [7:0] rdata;
    logic rvalid;
    logic fd_flag;
    logic ovr_flag;
    logic [7:0] trips;
    int n_mismatch = 0;
    int checked = 0;
    logic [7:0] regs [8] = '{8'h00, 8'h00, 8'hFF, 8'h0F, 8'h1D, 8'h0A, 8'h03, 8'h00};
    logic [13:0] vals [3] = '{14'h1000, 14'h3000, 14'h0FFF};

    always #2 clk_sys_i = ~clk_sys_i;

    adc_overrange_fast_detect u_dut (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .sample_i(samp),
        .reg_req_i(req),
        .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid),
        .fast_detect_flag_o(fd_flag),
        .overrange_flag_o(ovr_flag)
    );
    gain_ctrl_model u_gain (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .flag_i(fd_flag),
        .trip_count_o(trips)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys_i);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys_i);
        req <= '0;
        @(posedge clk_sys_i);
        chk({7'h00, rvalid}, 8'h01);
        d = rdata;
    endtask : rd
    task automatic pulse(input logic [13:0] d, input logic o);
        @(posedge clk_sys_i);
        samp <= '{d, o};
        @(posedge clk_sys_i);
        samp <= '0;
    endtask : pulse
    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    initial begin
        logic [7:0] v;
        step(2);
        rst_n_i <= 1'b1;
        chk({7'h00, fd_flag}, 8'h00);
        chk({7'h00, ovr_flag}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd(8'h45 + 8'(i), v);
            chk(v, (i == 6) ? 8'h01 : 8'h00);
        end
        wr(UPPER_THRESHOLD_LOW_ADDR, 8'hFF);
        wr(UPPER_THRESHOLD_HIGH_ADDR, 8'h0F);
        wr(LOWER_THRESHOLD_LOW_ADDR, 8'h1D);
        wr(LOWER_THRESHOLD_HIGH_ADDR, 8'h0A);
        wr(DWELL_TIME_LOW_ADDR, 8'h03);
        wr(8'h46, 8'h5A);
        for (int i = 0; i < 8; i++) begin
            rd(8'h45 + 8'(i), v);
            chk(v, regs[i]);
        end
        pulse(14'h1000, 1'b0);
        step(9);
        chk({7'h00, fd_flag}, 8'h00);
        wr(FAST_DETECT_CONTROL_ADDR, 8'h01);
        // positive, negative, then exactly at the upper threshold
        for (int i = 0; i < 3; i++) begin
            // the sample is taken at the edge that ends pulse; flag is seen seven edges on
            pulse(vals[i], 1'b0);
            step(6);
            chk({7'h00, fd_flag}, 8'h00);
            step(1);
            chk({7'h00, fd_flag}, {7'h00, i < 2});
            step(2);
            chk({7'h00, fd_flag}, {7'h00, i < 2});
            step(1);
            chk({7'h00, fd_flag}, 8'h00);
            step(5);
        end
        chk(trips, 8'h02);
        pulse(14'h0000, 1'b1);
        step(35);
        chk({7'h00, ovr_flag}, 8'h00);
        step(1);
        chk({7'h00, ovr_flag}, 8'h01);
        step(1);
        chk({7'h00, ovr_flag}, 8'h00);
        end_of_test();
    end

    initial begin
        step(3000);
        n_mismatch++;
        end_of_test();
    end
endmodule : test_adc_overrange_fast_detect
